// *** adcs_defs.svh ***
/*
 * offsets, field positions, reset values and timing counts of the converter sequencer.
 * assumes a 50 MHz ref_clk and 32-bit AXI4-Lite data with one register per aligned word.
 */
`ifndef ADCS_DEFS_SVH
`define ADCS_DEFS_SVH

// register indexes; byte address is four times the index
`define ADCS_IDX_RESULT 8'h1e
`define ADCS_IDX_CTRL 8'h1f
`define ADCS_IDX_PCFG 8'h20
`define ADCS_IDX_PORT 8'h21
`define ADCS_IDX_ISTAT 8'h22
`define ADCS_IDX_IMASK 8'h23
`define ADCS_IDX_FLAGS 8'h24

// converter_control fields
`define ADCS_CTRL_CS_HI 7
`define ADCS_CTRL_CS_LO 6
`define ADCS_CTRL_CH_HI 5
`define ADCS_CTRL_CH_LO 3
`define ADCS_CTRL_GO 2
`define ADCS_CTRL_ON 0
`define ADCS_CTRL_RST 8'h00
`define ADCS_CTRL_WMASK 8'hf9

// port_analog_config fields
`define ADCS_PCFG_ANA_HI 4
`define ADCS_PCFG_VREF 7
`define ADCS_PCFG_RST 8'h00
`define ADCS_PCFG_WMASK 8'h9f

// interrupt and flag bits
`define ADCS_IRQ_DONE 0
`define ADCS_FLAG_TADSHORT 0

// timing
`define ADCS_CLK_NS 20
`define ADCS_TAD_MIN_NS 1600
`define ADCS_TAD_MIN_CYC ((`ADCS_TAD_MIN_NS + `ADCS_CLK_NS - 1) / `ADCS_CLK_NS)
`define ADCS_HALF_DIV2 5'd1
`define ADCS_HALF_DIV8 5'd4
`define ADCS_HALF_DIV32 5'd16
`define ADCS_CONV_HALVES 5'd19
`define ADCS_NUM_CH 3'd5

`endif

// *** adcs_pkg.sv ***
/*
 * types shared by the converter sequencer files.
 * assumes adcs_defs.svh supplies all numeric constants.
 */
package adcs_pkg;
    // conversion clock source
    typedef enum logic [1:0] {
        CLK_DIV2 = 2'h0,
        CLK_DIV8 = 2'h1,
        CLK_DIV32 = 2'h2,
        CLK_RC = 2'h3
    } adcs_clksel_t;
    // successive approximation sequencer states
    typedef enum {SAR_IDLE, SAR_RUN} adcs_sar_t;
    // AXI answer code
    typedef logic [1:0] adcs_resp_t;
endpackage : adcs_pkg

// *** adcs_sar_engine.sv ***
/*
 * successive approximation sequencer: one conversion of 9.5 bit periods counted in half periods.
 * assumes halfTick is a one-cycle pulse per half bit period and cmpHigh is the comparator verdict
 * for the trial code presented on trialCode.
 */
`timescale 1ns/100ps
`include "adcs_defs.svh"
module adcs_sar_engine (
    input wire logic ref_clk, // core clock
    input wire logic nrst, // async reset, active low
    input wire logic enable, // converter powered
    input wire logic start, // one-cycle start request
    input wire logic halfTick, // half bit period pulse
    input wire logic cmpHigh, // input at or above trial code
    output logic busy, // conversion running
    output logic [7:0] trialCode, // code for the comparator
    output logic done, // one-cycle completion pulse
    output logic [7:0] result // final code, valid with done
);
    import adcs_pkg::*;

    adcs_sar_t state_r; // sequencer state
    logic [4:0] halfCnt_r; // half periods elapsed
    logic [7:0] bitPtr_r; // bit under trial, one-hot
    logic [7:0] trial_r; // trial code

    assign busy = (state_r == SAR_RUN);
    assign trialCode = trial_r;
    assign result = trial_r;

    // state and half-period count; power loss abandons the conversion
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            state_r <= SAR_IDLE;
            halfCnt_r <= 5'h00;
        end else if (!enable) begin
            state_r <= SAR_IDLE;
            halfCnt_r <= 5'h00;
        end else begin
            unique case (state_r)
                SAR_IDLE: begin
                    if (start) begin
                        state_r <= SAR_RUN;
                        halfCnt_r <= 5'h00;
                    end
                end
                SAR_RUN: begin
                    if (halfTick) begin
                        if (halfCnt_r == `ADCS_CONV_HALVES - 5'd1) begin
                            state_r <= SAR_IDLE;
                        end
                        halfCnt_r <= halfCnt_r + 5'd1;
                    end
                end
            endcase
        end
    end

    // bit decisions on the even half periods 2..16, one bit each
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            trial_r <= 8'h00;
            bitPtr_r <= 8'h00;
        end else if (start && state_r == SAR_IDLE && enable) begin
            trial_r <= 8'h80;
            bitPtr_r <= 8'h80;
        end else if (busy && halfTick && !halfCnt_r[0] && halfCnt_r >= 5'd2 && bitPtr_r != 8'h00) begin
            // keep or drop the trial bit
            trial_r <= (cmpHigh ? trial_r : (trial_r & ~bitPtr_r)) | (bitPtr_r >> 1);
            bitPtr_r <= bitPtr_r >> 1;
        end
    end

    // completion pulse in the cycle of the last half tick, so result and go clear land on one edge
    assign done = enable && busy && halfTick && (halfCnt_r == `ADCS_CONV_HALVES - 5'd1);
endmodule : adcs_sar_engine

// *** adcs_sequencer.sv ***
/*
 * converter sequencer control: AXI4-Lite register file, conversion clock divider,
 * channel and reference routing, result capture, done interrupt and analog port masking.
 * assumes the sample-and-hold and comparator sit outside; all inputs are synchronous to ref_clk.
 */
`timescale 1ns/100ps
`include "adcs_defs.svh"
module adcs_sequencer (
    input wire logic ref_clk, // 50 MHz core clock
    input wire logic nrst, // async reset, active low
    // AXI4-Lite slave
    input wire logic [11:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte enables
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output adcs_pkg::adcs_resp_t s_axi_bresp, // write answer
    output logic s_axi_bvalid, // write answer valid
    input wire logic s_axi_bready, // write answer ready
    input wire logic [11:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output adcs_pkg::adcs_resp_t s_axi_rresp, // read answer
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    // analog side
    input wire logic rcTick, // internal RC clock, one pulse per half period
    input wire logic cmpHigh, // comparator verdict
    input wire logic [4:0] portIn, // digital levels of the five port pins
    output logic [2:0] chanSel, // analog mux select
    output logic refExternal, // reference from pin when high
    output logic converterOn, // analog power enable
    output logic sampleHold, // hold the sample while high
    output logic [7:0] trialCode, // code to the comparator
    output logic irq // level interrupt
);
    import adcs_pkg::*;

    // register decode, used by both bus paths
    function automatic logic [7:0] addrIdx(input logic [11:0] a);
        addrIdx = a[9:2];
    endfunction : addrIdx

    function automatic logic idxValid(input logic [11:0] a);
        idxValid = (a[11:10] == 2'h0) && (addrIdx(a) >= `ADCS_IDX_RESULT) && (addrIdx(a) <= `ADCS_IDX_FLAGS);
    endfunction : idxValid

    logic [7:0] ctrl_r; // converter_control storage, go bit excluded
    logic [7:0] pcfg_r; // port_analog_config
    logic [7:0] result_r; // conversion_result
    logic istat_r; // sticky done flag
    logic imask_r; // done enable
    logic [11:0] awAddr_r; // latched write address
    logic awHeld_r; // write address taken
    logic [31:0] wData_r; // latched write data
    logic [3:0] wStrb_r; // latched byte enables
    logic wHeld_r; // write data taken
    logic bvalid_r; // write answer pending
    adcs_resp_t bresp_r; // write answer code
    logic rvalid_r; // read answer pending
    logic [31:0] rdata_r; // read data
    adcs_resp_t rresp_r; // read answer code
    logic [4:0] divCnt_r; // half period divider
    logic divTick; // divided half period pulse
    logic halfTick; // selected half period pulse
    logic [4:0] halfLen; // divider length for the selection; 16 needs five bits
    logic engineOn; // power seen by the engine; a control write counts its own on bit
    logic wrFire; // write performed this cycle
    logic wrCtrl; // write hits converter_control
    logic startReq; // start pulse to the engine
    logic busy; // conversion running
    logic convDone; // completion pulse
    logic [7:0] convResult; // final code
    logic [7:0] ctrlRead; // converter_control as read
    logic [4:0] portRead; // port data as read
    logic tadShort; // selected period below minimum
    logic [7:0] wByte; // low byte of the pending write

    assign wByte = wData_r[7:0];
    assign wrFire = awHeld_r && wHeld_r && !bvalid_r;
    assign wrCtrl = wrFire && idxValid(awAddr_r) && addrIdx(awAddr_r) == `ADCS_IDX_CTRL && wStrb_r[0];

    // start on go write while on
    assign startReq = wrCtrl && wByte[`ADCS_CTRL_GO] && wByte[`ADCS_CTRL_ON] && !busy;

    // AXI handshake outputs
    assign s_axi_awready = !awHeld_r;
    assign s_axi_wready = !wHeld_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    // write address channel; held until the write is performed
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            awHeld_r <= 1'b0;
            awAddr_r <= 12'h000;
        end else if (s_axi_awvalid && !awHeld_r) begin
            awHeld_r <= 1'b1;
            awAddr_r <= s_axi_awaddr;
        end else if (wrFire) begin
            awHeld_r <= 1'b0;
        end
    end

    // write data channel; either order with the address
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            wHeld_r <= 1'b0;
            wData_r <= 32'h0000_0000;
            wStrb_r <= 4'h0;
        end else if (s_axi_wvalid && !wHeld_r) begin
            wHeld_r <= 1'b1;
            wData_r <= s_axi_wdata;
            wStrb_r <= s_axi_wstrb;
        end else if (wrFire) begin
            wHeld_r <= 1'b0;
        end
    end

    // write answer; unmapped addresses answer SLVERR and change nothing
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            bvalid_r <= 1'b0;
            bresp_r <= 2'h0;
        end else if (wrFire) begin
            bvalid_r <= 1'b1;
            bresp_r <= idxValid(awAddr_r) ? 2'h0 : 2'h2;
        end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
        end
    end

    // control storage; go is not stored, it reads back the engine state
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            ctrl_r <= `ADCS_CTRL_RST;
        end else if (wrCtrl) begin
            ctrl_r <= wByte & `ADCS_CTRL_WMASK;
        end
    end

    // port configuration: analog pin set and reference choice
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            pcfg_r <= `ADCS_PCFG_RST;
        end else if (wrFire && idxValid(awAddr_r) && addrIdx(awAddr_r) == `ADCS_IDX_PCFG && wStrb_r[0]) begin
            pcfg_r <= wByte & `ADCS_PCFG_WMASK;
        end
    end

    // interrupt mask
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            imask_r <= 1'b0;
        end else if (wrFire && idxValid(awAddr_r) && addrIdx(awAddr_r) == `ADCS_IDX_IMASK && wStrb_r[0]) begin
            imask_r <= wByte[`ADCS_IRQ_DONE];
        end
    end

    // sticky done flag; a completion in the clearing cycle wins
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            istat_r <= 1'b0;
        end else if (convDone) begin
            istat_r <= 1'b1;
        end else if (wrFire && idxValid(awAddr_r) && addrIdx(awAddr_r) == `ADCS_IDX_ISTAT && wStrb_r[0]
                     && wByte[`ADCS_IRQ_DONE]) begin
            istat_r <= 1'b0;
        end
    end

    assign irq = istat_r && imask_r;

    // result captured on the completion pulse, the same edge that drops go
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            result_r <= 8'h00;
        end else if (convDone) begin
            result_r <= convResult;
        end
    end

    // half period length for the divided sources
    always_comb begin
        unique case (adcs_clksel_t'(ctrl_r[`ADCS_CTRL_CS_HI:`ADCS_CTRL_CS_LO]))
            CLK_DIV2: halfLen = `ADCS_HALF_DIV2;
            CLK_DIV8: halfLen = `ADCS_HALF_DIV8;
            CLK_DIV32: halfLen = `ADCS_HALF_DIV32;
            CLK_RC: halfLen = `ADCS_HALF_DIV32;
        endcase
    end

    // divider restarts with each conversion so the first period is whole
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            divCnt_r <= 5'h00;
        end else if (!busy || divTick) begin
            divCnt_r <= 5'h00;
        end else begin
            divCnt_r <= divCnt_r + 5'h01;
        end
    end

    assign divTick = busy && (divCnt_r == halfLen - 5'h01);
    // the RC source needs no core clock divider, so its tick passes straight through
    assign halfTick = (ctrl_r[`ADCS_CTRL_CS_HI:`ADCS_CTRL_CS_LO] == 2'h3) ? rcTick : divTick;

    // only the RC source can meet the minimum period at this core rate; flag shown to software
    always_comb begin
        tadShort = 1'b0;
        if (ctrl_r[`ADCS_CTRL_CS_HI:`ADCS_CTRL_CS_LO] != 2'h3) begin
            tadShort = ({26'h0, halfLen, 1'b0} < 32'(`ADCS_TAD_MIN_CYC));
        end
    end

    // one write may power up and start together, so the engine sees the value being written
    assign engineOn = wrCtrl ? wByte[`ADCS_CTRL_ON] : ctrl_r[`ADCS_CTRL_ON];
    adcs_sar_engine u_sar (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .enable(engineOn),
        .start(startReq),
        .halfTick(halfTick),
        .cmpHigh(cmpHigh),
        .busy(busy),
        .trialCode(trialCode),
        .done(convDone),
        .result(convResult)
    );

    // channel routing; converts whatever the code selects
    assign chanSel = ctrl_r[`ADCS_CTRL_CH_HI:`ADCS_CTRL_CH_LO];
    assign refExternal = pcfg_r[`ADCS_PCFG_VREF];
    assign converterOn = ctrl_r[`ADCS_CTRL_ON];
    assign sampleHold = busy;

    // go reads the running engine, cleared by hardware
    always_comb begin
        ctrlRead = ctrl_r;
        ctrlRead[`ADCS_CTRL_GO] = busy;
    end

    // analog pins read low on the port, one bit per pin
    genvar g;
    generate
        for (g = 0; g < 5; g++) begin : g_port
            assign portRead[g] = portIn[g] && !pcfg_r[g];
        end
    endgenerate

    // read channel; one read in flight, answered the cycle after the address
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rvalid_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
            rresp_r <= 2'h0;
        end else if (s_axi_arvalid && !rvalid_r) begin
            rvalid_r <= 1'b1;
            rresp_r <= idxValid(s_axi_araddr) ? 2'h0 : 2'h2;
            rdata_r <= 32'h0000_0000;
            if (idxValid(s_axi_araddr)) begin
                unique case (addrIdx(s_axi_araddr))
                    `ADCS_IDX_RESULT: rdata_r <= {24'h0, result_r};
                    `ADCS_IDX_CTRL: rdata_r <= {24'h0, ctrlRead};
                    `ADCS_IDX_PCFG: rdata_r <= {24'h0, pcfg_r};
                    `ADCS_IDX_PORT: rdata_r <= {27'h0, portRead};
                    `ADCS_IDX_ISTAT: rdata_r <= {31'h0, istat_r};
                    `ADCS_IDX_IMASK: rdata_r <= {31'h0, imask_r};
                    `ADCS_IDX_FLAGS: rdata_r <= {31'h0, tadShort};
                    default: rdata_r <= 32'h0000_0000;
                endcase
            end
        end else if (s_axi_rready) begin
            rvalid_r <= 1'b0;
        end
    end
endmodule : adcs_sequencer

// *** adcs_sequencer_chk.sv ***
/*
 * concurrent checks on the converter sequencer ports, bound into the top module.
 * assumes one clock domain and an asynchronous active-low reset.
 */
`timescale 1ns/100ps
module adcs_sequencer_chk (
    input wire logic ref_clk, // core clock
    input wire logic nrst, // reset, active low
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_wready, // w ready
    input wire logic s_axi_bvalid, // b valid
    input wire logic s_axi_bready, // b ready
    input wire logic s_axi_arvalid, // ar valid
    input wire logic s_axi_arready, // ar ready
    input wire logic s_axi_rvalid, // r valid
    input wire logic s_axi_rready, // r ready
    input wire logic [2:0] chanSel, // mux select
    input wire logic converterOn, // power enable
    input wire logic sampleHold, // conversion running
    input wire logic [7:0] trialCode, // trial code
    input wire logic irq // interrupt
);
    logic [15:0] runLen; // cycles the running conversion has lasted
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    // run length counter; a busy that never ends shows as an overlong run
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            runLen <= 16'h0000;
        end else if (sampleHold) begin
            runLen <= runLen + 16'h0001;
        end else begin
            runLen <= 16'h0000;
        end
    end
    a_write_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
        else $error("write answer late");
    a_write_release:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("write answer repeated");
    a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer late");
    a_read_release:
    assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("read answer repeated");
    a_first_trial:
    assert property ($rose(sampleHold) |-> trialCode == 8'h80) else $error("first trial not midscale");
    a_trial_quiet:
    assert property (!sampleHold [*3] |-> $stable(trialCode)) else $error("trial code moved while idle");
    a_start_on:
    assert property ($rose(sampleHold) |-> converterOn) else $error("conversion started while off");
    a_off_stop:
    assert property (!converterOn [*2] |-> !sampleHold) else $error("conversion runs while off");
    a_reset_clear:
    assert property ($rose(nrst) |-> !sampleHold && !converterOn && !irq && chanSel == 3'h0 && trialCode == 8'h00)
        else $error("outputs not cleared by reset");
    a_run_bound:
    assert property (sampleHold |-> runLen < 16'h0130) else $error("conversion longer than 9.5 periods");
endmodule : adcs_sequencer_chk

bind adcs_sequencer adcs_sequencer_chk u_adcs_sequencer_chk (.ref_clk, .nrst, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .s_axi_rready, .chanSel, .converterOn, .sampleHold, .trialCode, .irq);

// *** adcs_analog_model.sv ***
/*
 * behavioural sample-and-hold, comparator and free-running RC oscillator.
 * assumes levels carries one 8-bit input level per channel, channel 0 lowest.
 */
`timescale 1ns/100ps
module adcs_analog_model #(
    parameter int RC_HALF = 6 // cycles per RC half period
) (
    input wire logic ref_clk, // core clock
    input wire logic nrst, // reset, active low
    input wire logic [39:0] levels, // input levels
    input wire logic [2:0] chanSel, // selected channel
    input wire logic sampleHold, // hold request
    input wire logic [7:0] trialCode, // trial code
    output logic cmpHigh, // input at or above trial
    output logic rcTick // RC half period pulse
);
    logic [7:0] held; // held sample
    logic holdQ; // hold request one cycle ago
    logic junk; // meaningless verdict while not holding
    int rcCnt = 0; // RC phase, free running from time zero
    // the selected input is captured as the hold begins
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            held <= 8'h00;
            holdQ <= 1'b0;
            junk <= 1'b0;
        end else begin
            holdQ <= sampleHold;
            junk <= ~junk;
            if (sampleHold && !holdQ) begin
                held <= (chanSel < 3'h5) ? levels[{chanSel, 3'h0} +: 8] : 8'h00;
            end
        end
    end
    // RC oscillator runs free, independent of the core
    always @(posedge ref_clk) begin
        rcCnt <= (rcCnt >= RC_HALF - 1) ? 0 : rcCnt + 1;
    end
    assign rcTick = (rcCnt == RC_HALF - 1);
    // the verdict only means something while a sample is held
    assign cmpHigh = sampleHold ? (held >= trialCode) : junk;
endmodule : adcs_analog_model

// *** adcs_sequencer_tb_top.sv ***
/*
 * self-checking bench for the converter sequencer: AXI4-Lite master tasks, conversion rows, awkward cases.
 * assumes the analog model answers the comparator and makes the RC clock.
 */
`timescale 1ns/100ps
`include "adcs_defs.svh"
module adcs_sequencer_tb_top;
    import adcs_pkg::*;
    typedef struct packed {logic [1:0] sel; logic [2:0] ch; logic [7:0] mask; logic [4:0] half;} adcs_row_t;
    logic ref_clk, nrst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, rcTick, cmpHigh, refExternal, converterOn;
    logic sampleHold, irq;
    logic [11:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    adcs_resp_t s_axi_bresp, s_axi_rresp, rsp;
    logic [4:0] portIn;
    logic [2:0] chanSel;
    logic [7:0] trialCode;
    logic [39:0] levels = 40'hff_c3_81_45_00; // channel 4 down to channel 0
    int fails = 0, num_checks = 0, runLen = 0, lastLen = 0;
    // every clock select, RC included, and every channel, masked and unmasked
    adcs_row_t rows [5] = '{'{2'h0, 3'h0, 8'h01, 5'h01}, '{2'h1, 3'h1, 8'h00, 5'h04},
        '{2'h2, 3'h2, 8'h01, 5'h10}, '{2'h3, 3'h3, 8'h01, 5'h06}, '{2'h0, 3'h4, 8'h00, 5'h01}};

    adcs_sequencer u_adcs_sequencer (.ref_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rcTick,
        .cmpHigh, .portIn, .chanSel, .refExternal, .converterOn, .sampleHold, .trialCode, .irq);
    adcs_analog_model #(.RC_HALF(6)) u_adcs_analog_model (.ref_clk, .nrst, .levels, .chanSel, .sampleHold,
        .trialCode, .cmpHigh, .rcTick);

    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // length of the last conversion in cycles
    always @(posedge ref_clk) begin
        if (sampleHold === 1'b1) begin
            runLen <= runLen + 1;
        end else if (runLen != 0) begin
            lastLen <= runLen;
            runLen <= 0;
        end
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    task automatic give_up(input logic ok);
        if (!ok) begin
            fails++;
            $display("ERROR %0t: no answer in time", $time);
            wrap_up();
        end
    endtask : give_up
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: value %h expected %h", $time, got, exp);
        end
    endtask : chk_val
    task automatic chk_resp(input adcs_resp_t got, input adcs_resp_t exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("ERROR %0t: response %h expected %h", $time, got, exp);
        end
    endtask : chk_resp
    // write: address and data offered together, each released when taken
    task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d, output adcs_resp_t r);
        logic a, w, b;
        int n;
        @(posedge ref_clk);
        s_axi_awaddr <= {2'h0, idx, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        n = 0;
        b = 1'b0;
        while (!b && n < 60) begin
            @(negedge ref_clk);
            a = s_axi_awready;
            w = s_axi_wready;
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge ref_clk);
            if (a) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
            n++;
        end
        s_axi_bready <= 1'b0;
        give_up(b);
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] idx, output logic [31:0] d, output adcs_resp_t r);
        logic a, v;
        int n;
        @(posedge ref_clk);
        s_axi_araddr <= {2'h0, idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        n = 0;
        v = 1'b0;
        while (!v && n < 60) begin
            @(negedge ref_clk);
            a = s_axi_arready;
            v = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge ref_clk);
            if (a) s_axi_arvalid <= 1'b0;
            n++;
        end
        s_axi_rready <= 1'b0;
        give_up(v);
    endtask : axi_rd
    // poll the done status; go clears on the same edge that captures the result
    task automatic wait_done;
        int n;
        n = 0;
        rd = 32'h0;
        while (rd[0] !== 1'b1 && n < 200) begin
            axi_rd(`ADCS_IDX_ISTAT, rd, rsp);
            n++;
        end
        give_up(rd[0] === 1'b1);
    endtask : wait_done

    initial begin
        {nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 56'h0;
        s_axi_wstrb = 4'h1;
        portIn = 5'h1b;
        repeat (4) @(posedge ref_clk);
        nrst <= 1'b1;
        axi_rd(`ADCS_IDX_CTRL, rd, rsp);
        chk_val(rd, 32'h0);
        foreach (rows[i]) begin
            axi_wr(`ADCS_IDX_IMASK, rows[i].mask, rsp);
            axi_wr(`ADCS_IDX_CTRL, {rows[i].sel, rows[i].ch, 3'h5}, rsp);
            wait_done();
            axi_rd(`ADCS_IDX_RESULT, rd, rsp);
            chk_val(rd, {24'h0, levels[{rows[i].ch, 3'h0} +: 8]});
            chk_val({29'h0, chanSel}, {29'h0, rows[i].ch});
            axi_rd(`ADCS_IDX_CTRL, rd, rsp);
            chk_val(rd, {24'h0, rows[i].sel, rows[i].ch, 3'h1});
            chk_val({31'h0, irq}, {31'h0, rows[i].mask[0]});
            chk_val({31'h0, lastLen > 18 * rows[i].half && lastLen <= 19 * rows[i].half}, 32'h1);
            axi_wr(`ADCS_IDX_ISTAT, 8'h01, rsp);
            chk_val({31'h0, irq}, 32'h0);
            $display("row %0d done", i);
        end
        // unmapped place and read-only result
        axi_rd(8'h40, rd, rsp);
        chk_resp(rsp, 2'h2);
        axi_wr(`ADCS_IDX_RESULT, 8'h5a, rsp);
        axi_rd(`ADCS_IDX_RESULT, rd, rsp);
        chk_val(rd, 32'hff);
        // analog pins read low, reference from pin
        axi_wr(`ADCS_IDX_PCFG, 8'h85, rsp);
        axi_rd(`ADCS_IDX_PORT, rd, rsp);
        chk_val(rd, 32'h1a);
        chk_val({31'h0, refExternal}, 32'h1);
        axi_wr(`ADCS_IDX_CTRL, 8'h01, rsp);
        axi_rd(`ADCS_IDX_FLAGS, rd, rsp);
        chk_val(rd, 32'h1);
        $display("register tests done");
        // go while off is ignored; clearing on aborts without done
        axi_wr(`ADCS_IDX_CTRL, 8'h04, rsp);
        @(negedge ref_clk);
        chk_val({31'h0, sampleHold}, 32'h0);
        axi_wr(`ADCS_IDX_CTRL, 8'h85, rsp);
        chk_val({31'h0, sampleHold}, 32'h1);
        axi_wr(`ADCS_IDX_CTRL, 8'h80, rsp);
        @(negedge ref_clk);
        chk_val({31'h0, sampleHold}, 32'h0);
        axi_rd(`ADCS_IDX_ISTAT, rd, rsp);
        chk_val(rd, 32'h0);
        $display("power tests done");
        // reset in mid conversion
        axi_wr(`ADCS_IDX_CTRL, 8'h95, rsp);
        chk_val({31'h0, sampleHold}, 32'h1);
        @(posedge ref_clk);
        nrst <= 1'b0;
        @(posedge ref_clk);
        nrst <= 1'b1;
        @(negedge ref_clk);
        chk_val({29'h0, sampleHold, converterOn, irq}, 32'h0);
        axi_rd(`ADCS_IDX_CTRL, rd, rsp);
        chk_val(rd, 32'h0);
        $display("reset test done");
        wrap_up();
    end
endmodule : adcs_sequencer_tb_top
